// ==== design/eipcs_regs.svh ====
// register offsets, field positions and reset values of the error inject / loop clock bank
`ifndef EIPCS_REGS_SVH
`define EIPCS_REGS_SVH

`define EIPCS_OFF_ANALOG_PWR   8'h27
`define EIPCS_OFF_ERR_INJECT   8'h2d
`define EIPCS_OFF_LOOP_CLK_OVR 8'h35

`define EIPCS_BIT_FWD_ERR      7
`define EIPCS_BIT_LOOP_PWRDN   5
`define EIPCS_BIT_STRAP_OSC    3
`define EIPCS_BIT_AUX_TO_LOOP  1
`define EIPCS_BIT_LOOP_OSC     0

`define EIPCS_RST_ANALOG_PWR   8'h00
`define EIPCS_RST_ERR_INJECT   8'h00
`define EIPCS_RST_LOOP_CLK_OVR 8'h01

`endif

// ==== design/eipcs_pkg.sv ====
// types of the error inject / loop clock bank
package eipcs_pkg;

	// clock source feeding the forward channel loop
	typedef enum logic [1:0] {
		EIPCS_SRC_PIXEL,
		EIPCS_SRC_AUX_PIN,
		EIPCS_SRC_INT_OSC
	} eipcs_src_type;

	// register write/read request from the local serial control port
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} eipcs_req_type;

	// per-frame status from the serializer core
	typedef struct packed {
		logic frame_end;
		logic self_test_on;
	} eipcs_core_type;

endpackage : eipcs_pkg

// ==== design/eipcs_bank.sv ====
// error inject, loop clock select and loop power-down register bank
`timescale 1ns/1ps
`include "eipcs_regs.svh"

module eipcs_bank (
	// clock and reset
	input  wire  logic                   clk_sys,
	input  wire  logic                   reset,
	// register port
	input  wire  eipcs_pkg::eipcs_req_type req,
	output logic [7:0]                   rdata_r,
	output logic                         rvalid_r,
	// core status and straps
	input  wire  eipcs_pkg::eipcs_core_type core,
	input  wire  logic                   strap_ext_osc,
	input  wire  logic                   clock_to_loop_override,
	// controls to the serializer
	output logic                         corrupt_frame_r,
	output logic                         loop_power_down_r,
	output logic                         serial_out_enable_r,
	output eipcs_pkg::eipcs_src_type     loop_src_r
);
	import eipcs_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic       fwd_err_r, fwd_err_nxt;
	logic [6:0] st_cnt_r, st_cnt_nxt;
	logic [6:0] st_left_r, st_left_nxt;
	logic       st_on_r, st_on_nxt;
	logic [3:0] ovr_rsvd_r, ovr_rsvd_nxt;
	logic       aux_sel_r, aux_sel_nxt;
	logic       osc_sel_r, osc_sel_nxt;
	logic [7:0] apwr_r, apwr_nxt;
	logic [2:0] strap_sync_r, strap_sync_nxt;
	logic       strap_r, strap_nxt;
	logic [7:0] rdata_nxt;
	logic       rvalid_nxt;
	logic       corrupt_nxt;
	logic       pwrdn_nxt;
	logic       sout_nxt;
	eipcs_src_type src_nxt;
	logic       wr_inj;
	logic       wr_ovr;
	logic       wr_apwr;

	assign wr_inj  = req.wr && (req.addr == `EIPCS_OFF_ERR_INJECT);
	assign wr_ovr  = req.wr && (req.addr == `EIPCS_OFF_LOOP_CLK_OVR);
	assign wr_apwr = req.wr && (req.addr == `EIPCS_OFF_ANALOG_PWR);

	// ------------------------------------------------------------
	// strap synchroniser
	// ------------------------------------------------------------
	// the strap is a pin on no clock of ours: three stages, and the
	// status only moves once the last two agree, so a slow or bouncing
	// resistor level never shows a one-cycle glitch on readback
	always_comb begin
		strap_sync_nxt = {strap_sync_r[1:0], strap_ext_osc};
		strap_nxt      = strap_r;
		if (strap_sync_r[2] == strap_sync_r[1]) begin
			strap_nxt = strap_sync_r[2];
		end
	end

	// ------------------------------------------------------------
	// error injection next state
	// ------------------------------------------------------------
	// the forward error waits for normal mode; while self-test runs only
	// the counted errors go out, so the partner's count stays exact
	always_comb begin
		fwd_err_nxt    = fwd_err_r;
		st_cnt_nxt     = st_cnt_r;
		st_left_nxt    = st_left_r;
		st_on_nxt      = core.self_test_on;
		corrupt_nxt    = 1'b0;

		if (core.frame_end && !core.self_test_on && fwd_err_r) begin
			corrupt_nxt = 1'b1;
			fwd_err_nxt = 1'b0;
		end
		if (core.self_test_on && !st_on_r) begin
			st_left_nxt = st_cnt_r;
		end else if (core.self_test_on && core.frame_end && (st_left_r != 7'h00)) begin
			corrupt_nxt = 1'b1;
			st_left_nxt = st_left_r - 7'h01;
		end

		if (wr_inj) begin
			st_cnt_nxt = req.wdata[6:0];
			// zero write ignored; a set always wins over the clear
			if (req.wdata[`EIPCS_BIT_FWD_ERR]) begin
				fwd_err_nxt = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// clock override and analog power next state
	// ------------------------------------------------------------
	// bits 3 and 2 of the override register are never stored: bit 3 is
	// the live strap status and bit 2 reads zero
	always_comb begin
		ovr_rsvd_nxt   = ovr_rsvd_r;
		aux_sel_nxt    = aux_sel_r;
		osc_sel_nxt    = osc_sel_r;
		apwr_nxt       = apwr_r;
		if (wr_ovr) begin
			ovr_rsvd_nxt = req.wdata[7:4];
			aux_sel_nxt  = req.wdata[`EIPCS_BIT_AUX_TO_LOOP];
			osc_sel_nxt  = req.wdata[`EIPCS_BIT_LOOP_OSC];
		end
		// loop power-down bit stored with the rest; bits 7:6 read zero
		if (wr_apwr) begin
			apwr_nxt = {2'h0, req.wdata[5:0]};
		end
	end

	// ------------------------------------------------------------
	// outputs and read mux
	// ------------------------------------------------------------
	// read data is zero outside the answer cycle so a host that samples
	// late sees nothing stale; the loop source follows the override port
	// one edge later, and a change of source is left to the loop to ride out
	always_comb begin
		rvalid_nxt = req.rd;
		rdata_nxt  = 8'h00;
		if (req.addr == `EIPCS_OFF_ERR_INJECT) begin
			rdata_nxt = {fwd_err_r, st_cnt_r};
		end else if (req.addr == `EIPCS_OFF_LOOP_CLK_OVR) begin
			rdata_nxt = {ovr_rsvd_r, strap_r, 1'b0, aux_sel_r, osc_sel_r};
		end else if (req.addr == `EIPCS_OFF_ANALOG_PWR) begin
			rdata_nxt = apwr_r;
		end
		if (!req.rd) begin
			rdata_nxt = 8'h00;
		end
		pwrdn_nxt = apwr_r[`EIPCS_BIT_LOOP_PWRDN];
		// serial output stops while loop is down
		sout_nxt  = !apwr_r[`EIPCS_BIT_LOOP_PWRDN];
		src_nxt   = EIPCS_SRC_PIXEL;
		if (clock_to_loop_override) begin
			if (osc_sel_r) begin
				src_nxt = EIPCS_SRC_INT_OSC;
			end else if (aux_sel_r) begin
				src_nxt = EIPCS_SRC_AUX_PIN;
			end
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			fwd_err_r           <= 1'(`EIPCS_RST_ERR_INJECT >> `EIPCS_BIT_FWD_ERR);
			st_cnt_r            <= 7'h00;
			st_left_r           <= 7'h00;
			st_on_r             <= 1'b0;
			ovr_rsvd_r          <= 4'h0;
			aux_sel_r           <= 1'b0;
			osc_sel_r           <= 1'b1;
			apwr_r              <= `EIPCS_RST_ANALOG_PWR;
			strap_sync_r        <= 3'h0;
			strap_r             <= 1'b0;
			rdata_r             <= 8'h00;
			rvalid_r            <= 1'b0;
			corrupt_frame_r     <= 1'b0;
			loop_power_down_r   <= 1'b0;
			serial_out_enable_r <= 1'b1;
			loop_src_r          <= EIPCS_SRC_PIXEL;
		end else begin
			fwd_err_r           <= fwd_err_nxt;
			st_cnt_r            <= st_cnt_nxt;
			st_left_r           <= st_left_nxt;
			st_on_r             <= st_on_nxt;
			ovr_rsvd_r          <= ovr_rsvd_nxt;
			aux_sel_r           <= aux_sel_nxt;
			osc_sel_r           <= osc_sel_nxt;
			apwr_r              <= apwr_nxt;
			strap_sync_r        <= strap_sync_nxt;
			strap_r             <= strap_nxt;
			rdata_r             <= rdata_nxt;
			rvalid_r            <= rvalid_nxt;
			corrupt_frame_r     <= corrupt_nxt;
			loop_power_down_r   <= pwrdn_nxt;
			serial_out_enable_r <= sout_nxt;
			loop_src_r          <= src_nxt;
		end
	end

endmodule : eipcs_bank

// ==== tb/eipcs_props.sv ====
// port checks of the error inject / loop clock bank
`timescale 1ns/1ps
module eipcs_props import eipcs_pkg::*; (
	// watched ports
	input wire logic clk_sys,
	input wire logic reset,
	input wire eipcs_req_type req,
	input wire logic [7:0] rdata_r,
	input wire logic rvalid_r,
	input wire eipcs_core_type core,
	input wire logic strap_ext_osc,
	input wire logic clock_to_loop_override,
	input wire logic corrupt_frame_r,
	input wire logic loop_power_down_r,
	input wire logic serial_out_enable_r,
	input wire eipcs_src_type loop_src_r
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	sequence pwr_wr; req.wr && req.addr == 8'h27; endsequence
	// strap held long enough to pass its synchroniser
	sequence strap_rd; $stable(strap_ext_osc)[*6] ##0 (req.rd && req.addr == 8'h35); endsequence
	pwrdn_pair_a: assert property (serial_out_enable_r == !loop_power_down_r)
		else $error("serial enable not inverse of power-down");
	pwrdn_write_a: assert property (pwr_wr |-> ##2 loop_power_down_r == $past(req.wdata[5], 2))
		else $error("power-down does not follow write");
	pwrdn_hold_a: assert property (!(req.wr && req.addr == 8'h27) |-> ##2 $stable(loop_power_down_r))
		else $error("power-down moved without write");
	read_resp_a: assert property (req.rd |=> rvalid_r)
		else $error("read not answered");
	read_idle_a: assert property (!rvalid_r |-> rdata_r == 8'h00)
		else $error("read data outside answer");
	strap_read_a: assert property (strap_rd |=> rdata_r[3:2] == {$past(strap_ext_osc), 1'b0})
		else $error("strap status wrong");
	src_pixel_a: assert property (!$past(clock_to_loop_override) |-> loop_src_r == EIPCS_SRC_PIXEL)
		else $error("loop source without override");
	corrupt_cause_a: assert property (corrupt_frame_r |-> $past(core.frame_end))
		else $error("corruption without frame end");
endmodule : eipcs_props
bind eipcs_bank eipcs_props eipcs_props_inst (.clk_sys(clk_sys), .reset(reset), .req(req),
	.rdata_r(rdata_r), .rvalid_r(rvalid_r), .core(core), .strap_ext_osc(strap_ext_osc),
	.clock_to_loop_override(clock_to_loop_override), .corrupt_frame_r(corrupt_frame_r),
	.loop_power_down_r(loop_power_down_r), .serial_out_enable_r(serial_out_enable_r),
	.loop_src_r(loop_src_r));

// ==== tb/eipcs_host.sv ====
// host model driving the local register port
`timescale 1ns/1ps
module eipcs_host import eipcs_pkg::*; (
	// clock and request out
	input wire logic clk_sys,
	output eipcs_req_type req
);
	initial req = '0;
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		#1 req = '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clk_sys);
		// released qualifiers do not keep the old value
		#1 req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask : xfer
endmodule : eipcs_host

// ==== tb/error_inject_pll_clock_select_test.sv ====
// self-checking bench of the error inject / loop clock bank
`timescale 1ns/1ps
module error_inject_pll_clock_select_test;
	import eipcs_pkg::*;
	logic clk_sys = 0, reset = 1, ovr = 1, strap = 0, cor, pwd, sen, rvalid_r;
	logic [7:0] rdata_r, a, d, m27 = 8'h00, m35 = 8'h01;
	logic [31:0] seed = 32'd17666;
	eipcs_req_type req;
	eipcs_core_type core = '0;
	eipcs_src_type src;
	int num_errors = 0, comparisons = 0, n;
	byte unsigned cnt[4] = '{0, 1, 5, 127};
	always #50 clk_sys = !clk_sys;
	eipcs_host eipcs_host_inst (.clk_sys(clk_sys), .req(req));
	eipcs_bank eipcs_bank_inst (.clk_sys(clk_sys), .reset(reset), .req(req), .rdata_r(rdata_r),
		.rvalid_r(rvalid_r), .core(core), .strap_ext_osc(strap), .clock_to_loop_override(ovr),
		.corrupt_frame_r(cor), .loop_power_down_r(pwd), .serial_out_enable_r(sen), .loop_src_r(src));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [7:0] src_of(input logic o, input logic [7:0] r);
		return 8'(!o ? EIPCS_SRC_PIXEL : r[0] ? EIPCS_SRC_INT_OSC : r[1] ? EIPCS_SRC_AUX_PIN : EIPCS_SRC_PIXEL);
	endfunction : src_of
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
		eipcs_host_inst.xfer(0, ad, 8'h00);
		check("rdata", rdata_r, exp);
		check("rvalid", 8'(rvalid_r), 8'h01);
	endtask : rd
	task automatic frame();
		@(posedge clk_sys);
		#1 core.frame_end = 1;
		@(posedge clk_sys);
		#1 core.frame_end = 0;
	endtask : frame
	task automatic test_done();
		if (num_errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : test_done
	initial begin
		#2000000 num_errors++;
		test_done();
	end
	initial begin
		repeat (16) @(posedge clk_sys);
		// strap output held low across the release
		#1 reset = 0;
		// mode bits live outside this bank; the strap level is defined here
		rd(8'h2d, 8'h00);
		check("src", 8'(src), 8'(EIPCS_SRC_INT_OSC));
		// local restart: loop down, shortened wait, loop up
		eipcs_host_inst.xfer(1, 8'h27, 8'h20);
		repeat (200) @(posedge clk_sys);
		#1;
		check("pwd", 8'(pwd), 8'h01);
		check("sen", 8'(sen), 8'h00);
		eipcs_host_inst.xfer(1, 8'h27, 8'h00);
		repeat (3) @(posedge clk_sys);
		#1;
		check("sen", 8'(sen), 8'h01);
		repeat (24) begin
			{ovr, strap, a[1:0]} = 4'(rnd());
			d = 8'(rnd());
			a = a[0] ? 8'h35 : a[1] ? 8'h27 : 8'h28;
			m27 = a == 8'h27 ? d : m27;
			m35 = a == 8'h35 ? d : m35;
			eipcs_host_inst.xfer(1, a, d);
			repeat (6) @(posedge clk_sys);
			rd(8'h27, m27 & 8'h3f);
			rd(8'h35, {m35[7:4], strap, 1'b0, m35[1:0]});
			rd(8'h28, 8'h00);
			check("pwd", 8'(pwd), 8'(m27[5]));
			check("sen", 8'(sen), 8'(!m27[5]));
			check("src", 8'(src), src_of(ovr, m35));
		end
		eipcs_host_inst.xfer(1, 8'h2d, 8'h80);
		eipcs_host_inst.xfer(1, 8'h2d, 8'h00);
		rd(8'h2d, 8'h80);
		frame();
		check("corrupt", 8'(cor), 8'h01);
		rd(8'h2d, 8'h00);
		frame();
		check("corrupt", 8'(cor), 8'h00);
		foreach (cnt[k]) begin
			eipcs_host_inst.xfer(1, 8'h2d, cnt[k]);
			core.self_test_on = 1;
			n = 0;
			repeat (cnt[k] + 3) begin
				frame();
				n += (cor === 1'b1);
			end
			core.self_test_on = 0;
			check("errors", 8'(n), cnt[k]);
		end
		test_done();
	end
endmodule : error_inject_pll_clock_select_test
